// >>> inc/ecg_cfg_defs.svh
`ifndef ECG_CFG_DEFS_SVH
`define ECG_CFG_DEFS_SVH
// Behaviour
// (RL1) Frame control at 0x0A, reset 0x079000
// (RL2) Checksum word sent unless bit 9 set
// (RL3) Bit 7 drops unflagged pace/resp/leadoff words
// (RL4) Bit 6 repeats header while data not ready
// (RL5) Bit 4 picks lead or electrode format
// (RL6) Skip field decimates frames by 1, 2, 4
// (RL7) Rate field selects 2k/16k/128k/31.25 Hz
// (RL8) Host sets electrode format before 128k rate
// (RL9) Bit 5 puts notch in master path
// (RL10) Bit 4 bypasses notch when set
// (RL11) Low-pass corner field, resets to 40 Hz
// (RL12) Overrange error above max minus code*64
// (RL13) AC lead-off at or above upper code
// (RL14) Frame settings change only at frame boundary

// ==========================================================
// Register addresses
`define ADDR_FRAME_CTL          8'h0a
`define ADDR_FILTER             8'h0b
`define ADDR_LEADOFF_UPPER      8'h0c

// ==========================================================
// Reset values
`define RST_FRAME_CTL           24'h079000
`define RST_FILTER              24'h000000
`define RST_LEADOFF_UPPER       24'h00ffff

// ==========================================================
// Writable bit masks (reserved bits read zero)
`define MASK_FRAME_CTL          24'hfffedf
`define MASK_FILTER             24'h00003c
`define MASK_LEADOFF_UPPER      24'h0fffff

// ==========================================================
// Frame control fields
`define FC_PACE_OMIT            14
`define FC_RESPM_OMIT           13
`define FC_LOFF_OMIT            11
`define FC_CRC_OMIT             9
`define FC_AUTO_OMIT            7
`define FC_HDR_REPEAT           6
`define FC_FORMAT               4
`define FC_SKIP_HI              3
`define FC_SKIP_LO              2
`define FC_RATE_HI              1
`define FC_RATE_LO              0

// ==========================================================
// Filter and threshold fields
`define FL_MASTER_NOTCH         5
`define FL_NOTCH_BYPASS         4
`define FL_LPF_HI               3
`define FL_LPF_LO               2
`define LU_OVER_HI              19
`define LU_OVER_LO              16
`define LU_CODE_HI              15
`define LU_CODE_LO              0

// ==========================================================
// Converter full scale and overrange step shift (x64)
`define ADC_MAX_VALUE           24'hffffff
`define OVER_STEP_SHIFT         6
`endif

// >>> inc/ecg_cfg_pkg.sv
package ecg_cfg_pkg;
    // Output data rate codes
    typedef enum logic [1:0] {
        RATE_2K    = 2'h0,
        RATE_16K   = 2'h1,
        RATE_128K  = 2'h2,
        RATE_31HZ  = 2'h3
    } rate_t;

    // Low-pass corner codes
    typedef enum logic [1:0] {
        LPF_40HZ   = 2'h0,
        LPF_150HZ  = 2'h1,
        LPF_250HZ  = 2'h2,
        LPF_450HZ  = 2'h3
    } lpf_t;
endpackage

// >>> core/ecg_frame_filter_config.sv
`timescale 1ns/1ps
`include "ecg_cfg_defs.svh"

module ecg_frame_filter_config
    import ecg_cfg_pkg::*;
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         srst,
    // Register port from serial interface
    input  wire logic         reg_wr_en,
    input  wire logic         reg_rd_en,
    input  wire logic [7:0]   reg_addr,
    input  wire logic [23:0]  reg_wdata,
    output logic      [23:0]  reg_rdata,
    // Frame engine handshake
    input  wire logic         frame_start,
    input  wire logic         data_ready,
    input  wire logic         pace_flag,
    input  wire logic         resp_flag,
    input  wire logic         leadoff_flag,
    output logic              frame_send,
    output logic              header_only,
    output logic              pace_word_en,
    output logic              resp_magnitude_word_en,
    output logic              leadoff_word_en,
    output logic              checksum_word_en,
    output logic              output_format_sel,
    output rate_t             frame_rate_sel,
    output logic              format_conflict,
    // Filter controls
    input  wire logic         master_mode_pin,
    output logic              notch_in_path,
    output lpf_t              lowpass_corner_sel,
    // Converter and lead-off monitors
    input  wire logic         adc_valid,
    input  wire logic [23:0]  adc_sample,
    input  wire logic         ac_valid,
    input  wire logic [15:0]  ac_magnitude,
    output logic              adc_overrange,
    output logic              ac_leadoff
);

    // ==========================================================
    // Register file
    // Three 24-bit registers kept whole; fields are sliced where used
    logic [23:0] frame_ctl_q, frame_ctl_d;      // Live frame control
    logic [23:0] filter_q, filter_d;            // Filter settings
    logic [23:0] lo_upper_q, lo_upper_d;        // Lead-off upper limit
    logic [23:0] rdata_q, rdata_d;              // Read data

    // Writes land at once; reads answer one cycle later.
    // Reserved bits are masked on the way in, so they read back
    // as zero without a separate read mask.
    // A read and a write of the same address in one cycle return
    // the old contents; the write shows on the next read.
    // Unmapped addresses accept writes silently and read zero,
    // which keeps a host probing the map from stalling.
    always_comb
    begin
        frame_ctl_d = frame_ctl_q;
        filter_d    = filter_q;
        lo_upper_d  = lo_upper_q;
        rdata_d     = rdata_q;
        // Write path: mask reserved bits as the word lands
        if (reg_wr_en)
        begin
            unique case (reg_addr)
                `ADDR_FRAME_CTL:     frame_ctl_d = reg_wdata & `MASK_FRAME_CTL;     // RL1
                `ADDR_FILTER:        filter_d    = reg_wdata & `MASK_FILTER;
                `ADDR_LEADOFF_UPPER: lo_upper_d  = reg_wdata & `MASK_LEADOFF_UPPER;
                default:             ;  // Unmapped writes ignored
            endcase
        end
        // Read path: capture the addressed register
        if (reg_rd_en)
        begin
            unique case (reg_addr)
                `ADDR_FRAME_CTL:     rdata_d = frame_ctl_q;
                `ADDR_FILTER:        rdata_d = filter_q;
                `ADDR_LEADOFF_UPPER: rdata_d = lo_upper_q;
                default:             rdata_d = 24'h000000;  // Unmapped reads zero
            endcase
        end
    end

    // Register file storage
    // Reset loads the power-on defaults, so a host that never
    // writes still gets 2 kHz lead frames with every word present.
    // No clock enable: every flop loads each edge, holding by feedback
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            frame_ctl_q <= `RST_FRAME_CTL;          // RL1
            filter_q    <= `RST_FILTER;             // RL11
            lo_upper_q  <= `RST_LEADOFF_UPPER;      // RL13
            rdata_q     <= 24'h000000;
        end
        else
        begin
            frame_ctl_q <= frame_ctl_d;
            filter_q    <= filter_d;
            lo_upper_q  <= lo_upper_d;
            rdata_q     <= rdata_d;
        end
    end

    // ==========================================================
    // Frame sequencing
    // Active copy of frame control; taken only at frame_start so a
    // write mid-frame never yields a half-changed frame.
    // The host may write the control register at any time; the
    // frame engine only ever sees the copy taken at a boundary.
    // Every per-frame decision below is made on that same edge,
    // so all of a frame's outputs change together and then stand
    // until the next boundary.
    logic [23:0] active_q, active_d;            // Frame settings in use
    logic [1:0]  skip_cnt_q, skip_cnt_d;        // Decimation phase
    logic        send_q, send_d;                // Frame goes out
    logic        hdr_only_q, hdr_only_d;        // Header only
    logic        pace_en_q, pace_en_d;          // Pace word included
    logic        resp_en_q, resp_en_d;          // Resp magnitude included
    logic        loff_en_q, loff_en_d;          // Lead-off word included
    logic        crc_en_q, crc_en_d;            // Checksum word included
    logic        conflict_q, conflict_d;        // Format invalid at rate
    logic [23:0] nxt;                           // Settings for new frame
    logic [1:0]  skip_last;                     // Last phase before wrap

    // Next frame decisions
    // Decimation keeps a small phase counter instead of a frame
    // count; two bits cover the longest interval of four frames.
    // A change of the skip field restarts the phase so the first
    // frame after the change is always sent, which gives the host
    // a known alignment point.
    // Both upper-bit skip codes decimate by four, but moving
    // between them still counts as a change and restarts.
    always_comb
    begin
        nxt        = frame_ctl_q;
        active_d   = active_q;
        skip_cnt_d = skip_cnt_q;
        send_d     = send_q;
        hdr_only_d = hdr_only_q;
        pace_en_d  = pace_en_q;
        resp_en_d  = resp_en_q;
        loff_en_d  = loff_en_q;
        crc_en_d   = crc_en_q;
        conflict_d = conflict_q;
        // Decimation wrap: every, every other, every fourth
        if (nxt[`FC_SKIP_HI])
            skip_last = 2'h3;                                           // RL6
        else if (nxt[`FC_SKIP_LO])
            skip_last = 2'h1;                                           // RL6
        else
            skip_last = 2'h0;                                           // RL6
        if (frame_start)
        begin
            // Take the new settings for the whole frame
            active_d = nxt;                                             // RL14
            // Skip setting change restarts decimation phase
            if (nxt[`FC_SKIP_HI:`FC_SKIP_LO] != active_q[`FC_SKIP_HI:`FC_SKIP_LO]
                || skip_cnt_q >= skip_last)
                skip_cnt_d = 2'h0;
            else
                skip_cnt_d = skip_cnt_q + 2'h1;
            // Send on a restart or when the phase wraps
            send_d = (nxt[`FC_SKIP_HI:`FC_SKIP_LO] != active_q[`FC_SKIP_HI:`FC_SKIP_LO])
                     || (skip_cnt_q >= skip_last);                      // RL6
            // Repeat header alone until data is ready
            hdr_only_d = nxt[`FC_HDR_REPEAT] & ~data_ready;             // RL4
            // Optional words: fixed, or dropped when flag clear
            // A word omitted by its own bit stays out whatever its
            // flag says; auto omit only ever removes more words.
            pace_en_d = ~nxt[`FC_PACE_OMIT]
                        & (~nxt[`FC_AUTO_OMIT] | pace_flag);            // RL3
            resp_en_d = ~nxt[`FC_RESPM_OMIT]
                        & (~nxt[`FC_AUTO_OMIT] | resp_flag);            // RL3
            loff_en_d = ~nxt[`FC_LOFF_OMIT]
                        & (~nxt[`FC_AUTO_OMIT] | leadoff_flag);         // RL3
            crc_en_d  = ~nxt[`FC_CRC_OMIT];                             // RL2
            // Lead format only valid at 2k and 16k; host must avoid it
            // Indication only: the write is not refused, so a wrong
            // setting is visible rather than silently corrected.
            conflict_d = ~nxt[`FC_FORMAT] & nxt[`FC_RATE_HI];           // RL5 RL8
        end
    end

    // Frame sequencing storage
    // Outputs are quiet until the first boundary after reset, so
    // no frame is announced before the engine has started one.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            active_q   <= `RST_FRAME_CTL;
            skip_cnt_q <= 2'h0;
            send_q     <= 1'b0;
            hdr_only_q <= 1'b0;
            pace_en_q  <= 1'b0;
            resp_en_q  <= 1'b0;
            loff_en_q  <= 1'b0;
            crc_en_q   <= 1'b0;
            conflict_q <= 1'b0;
        end
        else
        begin
            active_q   <= active_d;
            skip_cnt_q <= skip_cnt_d;
            send_q     <= send_d;
            hdr_only_q <= hdr_only_d;
            pace_en_q  <= pace_en_d;
            resp_en_q  <= resp_en_d;
            loff_en_q  <= loff_en_d;
            crc_en_q   <= crc_en_d;
            conflict_q <= conflict_d;
        end
    end

    // ==========================================================
    // Filter control and monitors
    logic [1:0]  master_sync_q, master_sync_d;  // Pin synchroniser
    logic        notch_q, notch_d;              // Notch in signal path
    logic        over_q, over_d;                // Overrange error
    logic        leadoff_q, leadoff_d;          // AC lead-off detect
    logic [23:0] over_limit;                    // Overrange threshold
    logic [3:0]  over_code;                     // Overrange code

    // Notch source and threshold compares
    // The master mode pin is asynchronous to clk; only the second
    // synchroniser stage is read, so a metastable first stage
    // never reaches the notch select.
    // The overrange limit is rebuilt every cycle from the code;
    // the subtraction cannot underflow since the largest step is
    // far below full scale.
    // Both monitors hold their last verdict between samples so the
    // frame engine can read them at any point in the frame.
    // A threshold write applies from the next sample on; verdicts
    // already taken are not revisited.
    always_comb
    begin
        master_sync_d = {master_sync_q[0], master_mode_pin};
        over_code     = lo_upper_q[`LU_OVER_HI:`LU_OVER_LO];
        over_limit    = `ADC_MAX_VALUE - (24'(over_code) << `OVER_STEP_SHIFT);   // RL12
        // Master path uses its own enable; otherwise bypass bit
        // The two bits have opposite sense: one enables, one bypasses
        if (master_sync_q[1])
            notch_d = filter_q[`FL_MASTER_NOTCH];                       // RL9
        else
            notch_d = ~filter_q[`FL_NOTCH_BYPASS];                      // RL10
        // Hold both verdicts between samples
        over_d    = over_q;
        leadoff_d = leadoff_q;
        // Code zero disables the overrange check
        if (adc_valid)
            over_d = (over_code != 4'h0) && (adc_sample > over_limit);   // RL12
        // Lead-off once the magnitude reaches the upper code
        if (ac_valid)
            leadoff_d = ac_magnitude >= lo_upper_q[`LU_CODE_HI:`LU_CODE_LO];   // RL13
    end

    // Filter and monitor storage
    // Notch resets to in circuit, matching a zero filter register
    // on the non-master path.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            master_sync_q <= 2'h0;
            notch_q       <= 1'b1;
            over_q        <= 1'b0;
            leadoff_q     <= 1'b0;
        end
        else
        begin
            master_sync_q <= master_sync_d;
            notch_q       <= notch_d;
            over_q        <= over_d;
            leadoff_q     <= leadoff_d;
        end
    end

    // ==========================================================
    // Outputs, all straight from flops
    // Format and rate come from the active copy, not the live
    // register, so they follow the frame boundary as well.
    // Plain wires only; no logic sits between flop and port
    assign reg_rdata              = rdata_q;
    assign frame_send             = send_q;
    assign header_only            = hdr_only_q;
    assign pace_word_en           = pace_en_q;
    assign resp_magnitude_word_en = resp_en_q;
    assign leadoff_word_en        = loff_en_q;
    assign checksum_word_en       = crc_en_q;
    assign output_format_sel      = active_q[`FC_FORMAT];                                 // RL5
    assign frame_rate_sel         = rate_t'(active_q[`FC_RATE_HI:`FC_RATE_LO]);          // RL7
    assign format_conflict        = conflict_q;
    assign notch_in_path          = notch_q;
    assign lowpass_corner_sel     = lpf_t'(filter_q[`FL_LPF_HI:`FL_LPF_LO]);             // RL11
    assign adc_overrange          = over_q;
    assign ac_leadoff             = leadoff_q;

endmodule

// >>> verification/ecg_cfg_assertions.sv
`timescale 1ns/1ps
// ==========================================================
// Port checker for the configuration bank
module ecg_cfg_checker
    import ecg_cfg_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // Register port
    input  wire logic        reg_wr_en,
    input  wire logic        reg_rd_en,
    input  wire logic [23:0] reg_rdata,
    // Frame port
    input  wire logic        frame_start,
    input  wire logic        data_ready,
    input  wire logic        header_only,
    input  wire logic        output_format_sel,
    input  wire rate_t       frame_rate_sel,
    input  wire lpf_t        lowpass_corner_sel,
    // Monitors
    input  wire logic        adc_valid,
    input  wire logic [23:0] adc_sample,
    input  wire logic        adc_overrange,
    input  wire logic        ac_valid,
    input  wire logic [15:0] ac_magnitude,
    input  wire logic        ac_leadoff
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    property p_rd_hold; !$past(reg_rd_en) |-> $stable(reg_rdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    // Active settings only move at a frame boundary
    property p_frm_hold;
        !$past(frame_start) |-> $stable(frame_rate_sel) && $stable(output_format_sel);
    endproperty
    a_frm_hold: assert property (p_frm_hold) else $error("frame setting moved");
    property p_hdr; $rose(header_only) |-> $past(frame_start && !data_ready); endproperty
    a_hdr: assert property (p_hdr) else $error("header only without cause");
    // Corner is a plain register field, so it moves only after a write
    property p_lpf; !$past(reg_wr_en) |-> $stable(lowpass_corner_sel); endproperty
    a_lpf: assert property (p_lpf) else $error("corner moved");
    property p_ovr_low; adc_valid && adc_sample <= 24'hfffc3f |=> !adc_overrange; endproperty
    a_ovr_low: assert property (p_ovr_low) else $error("overrange too low");
    property p_ovr_hold; !$past(adc_valid) |-> $stable(adc_overrange); endproperty
    a_ovr_hold: assert property (p_ovr_hold) else $error("overrange moved");
    property p_ac_top; ac_valid && ac_magnitude == 16'hffff |=> ac_leadoff; endproperty
    a_ac_top: assert property (p_ac_top) else $error("full scale not lead-off");
    property p_ac_hold; !$past(ac_valid) |-> $stable(ac_leadoff); endproperty
    a_ac_hold: assert property (p_ac_hold) else $error("lead-off moved");
endmodule

bind ecg_frame_filter_config ecg_cfg_checker i_chk (.*);

// >>> verification/ecg_frame_src.sv
`timescale 1ns/1ps
// ==========================================================
// Frame engine stand-in: one boundary pulse per request
module ecg_frame_src
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // Request from the bench
    input  wire logic       go,
    input  wire logic       rdy,
    input  wire logic [2:0] flg,
    // Boundary and header flags
    output logic            frame_start,
    output logic            data_ready,
    output logic            pace_flag,
    output logic            resp_flag,
    output logic            leadoff_flag
);
    logic [3:0] hdr_q; // Header latched with the request
    // Pulse follows the request by one edge
    always_ff @(posedge clk)
    begin
        frame_start <= go && !srst;
        hdr_q       <= {rdy, flg};
    end
    // Off the boundary the lines carry junk, so stale values cannot pass
    assign {data_ready, pace_flag, resp_flag, leadoff_flag} = frame_start ? hdr_q : ~hdr_q;
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// Bench for the configuration bank
module tb_top;
    import ecg_cfg_pkg::*;
    logic clk = 0, srst = 1, reg_wr_en = 0, reg_rd_en = 0, go = 0, rdy = 1;
    logic master_mode_pin = 0, adc_valid = 0, ac_valid = 0;
    logic [2:0] flg = 0;
    logic [7:0] reg_addr = 0;
    logic [23:0] reg_wdata = 0, adc_sample = 0, reg_rdata;
    logic [15:0] ac_magnitude = 0;
    logic frame_start, data_ready, pace_flag, resp_flag, leadoff_flag, frame_send, header_only;
    logic pace_word_en, resp_magnitude_word_en, leadoff_word_en, checksum_word_en;
    logic output_format_sel, format_conflict, notch_in_path, adc_overrange, ac_leadoff;
    rate_t frame_rate_sel;
    lpf_t lowpass_corner_sel;
    int num_errors = 0, compares = 0, i, k;
    ecg_frame_filter_config i_dut (.*);
    ecg_frame_src i_src (.*);
    always #2 clk = ~clk;
    // ==========================================================
    // Access tasks wrr, rdc, frm and mon start one edge later; chk and summarize act at once
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        compares++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wrr(input logic [7:0] a, input logic [23:0] d);
        @(posedge clk) #1 {reg_addr, reg_wdata, reg_wr_en} = {a, d, 1'b1};
        @(posedge clk) #1 reg_wr_en = 0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [23:0] e);
        @(posedge clk) #1 {reg_addr, reg_rd_en} = {a, 1'b1};
        @(posedge clk) #1 reg_rd_en = 0;
        chk("reg_rdata", e, reg_rdata);
    endtask
    task automatic frm(input logic r, input logic [2:0] f);
        @(posedge clk) #1 {go, rdy, flg} = {1'b1, r, f};
        @(posedge clk) #1 go = 0;
        @(posedge clk) #1;
    endtask
    task automatic mon(input logic [23:0] s, input logic [15:0] m);
        @(posedge clk) #1 {adc_sample, ac_magnitude, adc_valid, ac_valid} = {s, m, 2'b11};
        @(posedge clk) #1 {adc_valid, ac_valid} = 2'b00;
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Watchdog cuts a hang short
    initial
    begin
        repeat (5000) @(posedge clk);
        num_errors++;
        summarize();
    end
    // ==========================================================
    // Test sequence
    initial
    begin
        repeat (16) @(posedge clk);
        #1 srst = 0;
        rdc(8'h0a, 24'h079000);
        rdc(8'h0b, 24'h000000);
        rdc(8'h0c, 24'h00ffff);
        for (i = 10; i < 14; i++) wrr(i[7:0], 24'hffffff);
        rdc(8'h0a, 24'hfffedf);
        rdc(8'h0b, 24'h00003c);
        rdc(8'h0c, 24'h0fffff);
        rdc(8'h0d, 24'h000000);
        $display("test registers done");
        wrr(8'h0a, 24'h079215);
        chk("frame_rate_sel", 24'h0, {22'h0, frame_rate_sel});
        for (i = 0; i < 3; i++)
        begin
            frm(1, 3'h7);
            chk("frame", {4'h6, ~i[0]}, {frame_rate_sel, output_format_sel, checksum_word_en, frame_send});
        end
        for (k = 2; k < 4; k++)
        begin
            wrr(8'h0a, 24'h079010 | (k << 2));
            for (i = 0; i < 5; i++)
            begin
                frm(1, 3'h7);
                chk("frame_send", i % 4 == 0, frame_send);
            end
        end
        for (k = 0; k < 4; k++)
        begin
            wrr(8'h0a, 24'h079010 | k);
            frm(1, 3'h7);
            chk("rate conflict", {k[1:0], 1'b0}, {frame_rate_sel, format_conflict});
        end
        wrr(8'h0a, 24'h079000);
        frm(1, 3'h7);
        chk("fmt crc", 2'h1, {output_format_sel, checksum_word_en});
        wrr(8'h0a, 24'h079003);
        frm(1, 3'h7);
        chk("format_conflict", 1, format_conflict);
        $display("test frame settings done");
        wrr(8'h0a, 24'h079040);
        frm(0, 3'h7);
        chk("header_only", 1, header_only);
        frm(1, 3'h7);
        chk("header_only", 0, header_only);
        wrr(8'h0a, 24'h079080);
        frm(1, 3'h0);
        chk("auto omit", 3'h0, {pace_word_en, resp_magnitude_word_en, leadoff_word_en});
        frm(0, 3'h5);
        chk("hdr words", 4'h5, {header_only, pace_word_en, resp_magnitude_word_en, leadoff_word_en});
        wrr(8'h0a, 24'h079000);
        frm(1, 3'h0);
        chk("fixed words", 3'h7, {pace_word_en, resp_magnitude_word_en, leadoff_word_en});
        $display("test frame words done");
        for (k = 0; k < 4; k++)
        begin
            wrr(8'h0b, 24'h000020 | (k << 2));
            repeat (2) @(posedge clk);
            #1;
            chk("corner notch", {k[1:0], 1'b1}, {lowpass_corner_sel, notch_in_path});
        end
        wrr(8'h0b, 24'h000010);
        repeat (2) @(posedge clk);
        #1;
        chk("notch_in_path", 0, notch_in_path);
        wrr(8'h0b, 24'h000000);
        repeat (2) @(posedge clk);
        #1;
        chk("notch_in_path", 1, notch_in_path);
        master_mode_pin = 1;
        repeat (5) @(posedge clk);
        #1;
        chk("notch_in_path", 0, notch_in_path);
        wrr(8'h0b, 24'h000020);
        repeat (2) @(posedge clk);
        #1;
        chk("notch_in_path", 1, notch_in_path);
        $display("test filter done");
        wrr(8'h0c, 24'h011000);
        mon(24'hffffc0, 16'h1000);
        chk("over leadoff", 2'h3, {adc_overrange, ac_leadoff});
        mon(24'hffffbf, 16'h0fff);
        chk("over leadoff", 2'h0, {adc_overrange, ac_leadoff});
        wrr(8'h0c, 24'h0f0000);
        mon(24'hfffc40, 16'h0000);
        chk("over leadoff", 2'h3, {adc_overrange, ac_leadoff});
        mon(24'hfffc3f, 16'h0000);
        chk("over leadoff", 2'h1, {adc_overrange, ac_leadoff});
        wrr(8'h0c, 24'h00ffff);
        mon(24'hffffff, 16'hfffe);
        chk("over leadoff", 2'h0, {adc_overrange, ac_leadoff});
        mon(24'h000000, 16'hffff);
        chk("ac_leadoff", 1, ac_leadoff);
        $display("test monitors done");
        summarize();
    end
endmodule
